// [rtl/isd_ptr_alu.sv]
// Function
// - Add six-bit literal to selected pointer, one cycle
// - Select bits 11 add to third pointer, return
// - Subtract six-bit literal from selected pointer, one cycle
// - Select bits 11 subtract third pointer, return
// - Fixed word calls working register target, two cycles
// - Indexed to absolute move, two words, two cycles
// - Indexed to indexed move, two words, two cycles
// - Push literal at third pointer, then decrement
// - Extensions execute only with enable bit set
// - Returns load counter from stack top; second idle
// - Call pushes counter plus two, loads latches
package isd_pkg;
	localparam int PTR_W = 12;
	localparam int PC_W = 21;
	localparam int PHASE_W = 2;
	// Quarter phases of one instruction cycle.
	localparam logic [1:0] PH_DECODE = 2'h0;
	localparam logic [1:0] PH_READ = 2'h1;
	localparam logic [1:0] PH_PROCESS = 2'h2;
	localparam logic [1:0] PH_WRITE = 2'h3;
	// Opcode fields.
	localparam logic [7:0] OPC_PTR_ADD = 8'hE8;
	localparam logic [7:0] OPC_PTR_SUB = 8'hE9;
	localparam logic [7:0] OPC_PUSH = 8'hEA;
	localparam logic [7:0] OPC_MOVE = 8'hEB;
	localparam logic [15:0] OPC_WORKING_REGISTER_CALL = 16'h0014;
	localparam logic [3:0] OPC_SECOND_WORD = 4'hF;
	localparam logic [1:0] SEL_THIRD = 2'h3;
	localparam int SEL_LSB = 6;
	localparam int MOVE_KIND_BIT = 7;
	localparam logic [PC_W-1:0] CALL_RET_STEP = 21'h0_0002;
	localparam logic [7:0] PUSH_STEP = 8'h01;
	localparam logic [PTR_W-1:0] PTR_RESET = 12'h000;
	typedef enum logic [3:0] {
		OP_NONE,
		OP_PTR_ADD,
		OP_PTR_SUB,
		OP_ADD_RET,
		OP_SUB_RET,
		OP_WORKING_REGISTER_CALL,
		OP_ABS_MOVE,
		OP_IDX_MOVE,
		OP_PUSH
	} isd_op_t;
	typedef enum logic [1:0] {
		ST_EXEC,
		ST_IDLE_CYCLE,
		ST_MOVE_SECOND
	} isd_state_t;
	typedef struct packed {
		logic [PHASE_W-1:0] phase;
		isd_state_t st;
		isd_op_t op;
		logic [15:0] ir;
		logic [2:0][PTR_W-1:0] ptr;
		logic [7:0] data;
		logic claim;
		logic pc_load;
		logic [PC_W-1:0] pc_value;
		logic pop;
		logic push;
		logic [PC_W-1:0] push_value;
		logic re;
		logic [PTR_W-1:0] raddr;
		logic we;
		logic [PTR_W-1:0] waddr;
		logic [7:0] wdata;
	} isd_regs_t;
endpackage

module isd_ptr_alu
(
	// Operands
	input wire logic [isd_pkg::PTR_W-1:0] base_i,
	input wire logic [7:0] literal_i,
	input wire logic subtract_i,
	// Result
	output logic [isd_pkg::PTR_W-1:0] result_o
);
	import isd_pkg::*;

	logic [PTR_W-1:0] ext_lit;

	assign ext_lit = {{(PTR_W-8){1'b0}}, literal_i};
	// The carry out is dropped on purpose: pointers wrap modulo 4096.
	assign result_o = subtract_i ? base_i - ext_lit : base_i + ext_lit;
endmodule // isd_ptr_alu

// [rtl/isd_decode.sv]
module isd_decode
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Fetch and core state
	input wire logic [15:0] instr_word_i,
	input wire logic ext_enable_i,
	input wire logic [7:0] working_register_i,
	input wire logic [7:0] counter_high_latch_i,
	input wire logic [4:0] counter_upper_latch_i,
	input wire logic [isd_pkg::PC_W-1:0] pc_i,
	input wire logic [isd_pkg::PC_W-1:0] return_stack_top_i,
	input wire logic [7:0] mem_rdata_i,
	// Phase and claim
	output logic [1:0] phase_o,
	output logic claim_o,
	// Program counter and return stack
	output logic pc_load_o,
	output logic [isd_pkg::PC_W-1:0] pc_value_o,
	output logic stack_pop_o,
	output logic stack_push_o,
	output logic [isd_pkg::PC_W-1:0] stack_push_value_o,
	// Data memory
	output logic mem_re_o,
	output logic [isd_pkg::PTR_W-1:0] mem_raddr_o,
	output logic mem_we_o,
	output logic [isd_pkg::PTR_W-1:0] mem_waddr_o,
	output logic [7:0] mem_wdata_o,
	// Pointer registers
	output logic [isd_pkg::PTR_W-1:0] pointer_register0_o,
	output logic [isd_pkg::PTR_W-1:0] pointer_register1_o,
	output logic [isd_pkg::PTR_W-1:0] third_pointer_register_o
);
	import isd_pkg::*;

	// ****************************************
	// Decoding
	// ****************************************

	function automatic isd_op_t decode_word(input logic [15:0] w);
		isd_op_t op;
		op = OP_NONE;
		if (w == OPC_WORKING_REGISTER_CALL)
			op = OP_WORKING_REGISTER_CALL;
		else if (w[15:8] == OPC_PTR_ADD)
			op = (w[7:6] == SEL_THIRD) ? OP_ADD_RET : OP_PTR_ADD;
		else if (w[15:8] == OPC_PTR_SUB)
			op = (w[7:6] == SEL_THIRD) ? OP_SUB_RET : OP_PTR_SUB;
		else if (w[15:8] == OPC_PUSH)
			op = OP_PUSH;
		else if (w[15:8] == OPC_MOVE)
			op = w[MOVE_KIND_BIT] ? OP_IDX_MOVE : OP_ABS_MOVE;
		return op;
	endfunction

	function automatic logic is_two_cycle(input isd_op_t op);
		return op inside {OP_ADD_RET, OP_SUB_RET, OP_WORKING_REGISTER_CALL,
			OP_ABS_MOVE, OP_IDX_MOVE};
	endfunction

	// ****************************************
	// Pointer arithmetic
	// ****************************************

	isd_regs_t r;
	isd_regs_t next_r;
	logic [1:0] sel;
	logic [PTR_W-1:0] alu_base;
	logic [7:0] alu_lit;
	logic alu_sub;
	logic [PTR_W-1:0] alu_result;

	assign sel = r.ir[SEL_LSB+1:SEL_LSB];

	always_comb
	begin
		alu_base = r.ptr[2];
		alu_lit = {1'b0, r.ir[6:0]};
		alu_sub = 1'b0;
		unique case (r.op)
			OP_PTR_ADD, OP_PTR_SUB:
			begin
				alu_base = r.ptr[sel];
				alu_lit = {2'b00, r.ir[5:0]};
				alu_sub = (r.op == OP_PTR_SUB);
			end
			OP_ADD_RET, OP_SUB_RET:
			begin
				alu_lit = {2'b00, r.ir[5:0]};
				alu_sub = (r.op == OP_SUB_RET);
			end
			OP_PUSH:
			begin
				alu_lit = PUSH_STEP;
				alu_sub = 1'b1;
			end
			OP_NONE, OP_WORKING_REGISTER_CALL, OP_ABS_MOVE, OP_IDX_MOVE:
			begin
			end
		endcase
	end

	isd_ptr_alu u_alu
	(
		.base_i(alu_base),
		.literal_i(alu_lit),
		.subtract_i(alu_sub),
		.result_o(alu_result)
	);

	// ****************************************
	// Sequencing
	// ****************************************

	always_comb
	begin
		next_r = r;
		next_r.phase = r.phase + 2'h1;
		next_r.pc_load = 1'b0;
		next_r.pop = 1'b0;
		next_r.push = 1'b0;
		next_r.re = 1'b0;
		next_r.we = 1'b0;
		unique case (r.phase)
			PH_DECODE:
			begin
				if (r.st == ST_EXEC)
				begin
					next_r.ir = instr_word_i;
					next_r.op = ext_enable_i ? decode_word(instr_word_i) : OP_NONE;
					next_r.claim = ext_enable_i && (decode_word(instr_word_i) != OP_NONE);
				end
				else if (r.st == ST_MOVE_SECOND)
					next_r.ir = instr_word_i;
			end
			PH_READ:
			begin
				if (r.st == ST_EXEC && (r.op == OP_ABS_MOVE || r.op == OP_IDX_MOVE))
				begin
					next_r.re = 1'b1;
					next_r.raddr = alu_result;
				end
			end
			PH_PROCESS:
			begin
				if (r.re)
					next_r.data = mem_rdata_i;
			end
			PH_WRITE:
			begin
				next_r.st = ST_EXEC;
				if (r.st == ST_EXEC)
				begin
					unique case (r.op)
						OP_PTR_ADD, OP_PTR_SUB:
							next_r.ptr[sel] = alu_result;
						OP_ADD_RET, OP_SUB_RET:
						begin
							next_r.ptr[2] = alu_result;
							next_r.pc_load = 1'b1;
							next_r.pc_value = return_stack_top_i;
							next_r.pop = 1'b1;
						end
						OP_WORKING_REGISTER_CALL:
						begin
							next_r.push = 1'b1;
							next_r.push_value = pc_i + CALL_RET_STEP;
							next_r.pc_load = 1'b1;
							next_r.pc_value = {counter_upper_latch_i,
								counter_high_latch_i, working_register_i};
						end
						OP_PUSH:
						begin
							next_r.we = 1'b1;
							next_r.waddr = r.ptr[2];
							next_r.wdata = r.ir[7:0];
							next_r.ptr[2] = alu_result;
						end
						OP_NONE, OP_ABS_MOVE, OP_IDX_MOVE:
						begin
						end
					endcase
					if (is_two_cycle(r.op))
						next_r.st = (r.op == OP_ABS_MOVE || r.op == OP_IDX_MOVE) ?
							ST_MOVE_SECOND : ST_IDLE_CYCLE;
				end
				else if (r.st == ST_MOVE_SECOND)
				begin
					next_r.we = 1'b1;
					next_r.wdata = r.data;
					next_r.waddr = (r.op == OP_ABS_MOVE) ? r.ir[11:0] : alu_result;
				end
				else
					next_r.claim = r.claim;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			r <= '0;
			r.st <= ST_EXEC;
			r.op <= OP_NONE;
			r.ptr <= {3{PTR_RESET}};
		end
		else
			r <= next_r;
	end

	assign phase_o = r.phase;
	assign claim_o = r.claim;
	assign pc_load_o = r.pc_load;
	assign pc_value_o = r.pc_value;
	assign stack_pop_o = r.pop;
	assign stack_push_o = r.push;
	assign stack_push_value_o = r.push_value;
	assign mem_re_o = r.re;
	assign mem_raddr_o = r.raddr;
	assign mem_we_o = r.we;
	assign mem_waddr_o = r.waddr;
	assign mem_wdata_o = r.wdata;
	assign pointer_register0_o = r.ptr[0];
	assign pointer_register1_o = r.ptr[1];
	assign third_pointer_register_o = r.ptr[2];

	// ****************************************
	// Checks
	// ****************************************

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);

	sequence move_read_s;
		mem_re_o && (r.op == OP_ABS_MOVE || r.op == OP_IDX_MOVE);
	endsequence
	sequence move_write_s;
		mem_we_o && mem_wdata_o == $past(mem_rdata_i, 6);
	endsequence

	chk_phase_order: assert property (
		phase_o == PH_WRITE |=> phase_o == PH_DECODE)
		else $error("phase did not wrap to decode");
	chk_claim_enable: assert property (
		$rose(claim_o) |-> $past(ext_enable_i))
		else $error("extension claimed while disabled");
	chk_return_load: assert property (
		stack_pop_o |-> pc_load_o &&
		pc_value_o == $past(return_stack_top_i))
		else $error("return did not load stack top");
	chk_return_idle: assert property (
		stack_pop_o |=> (!mem_we_o && !pc_load_o) [*7])
		else $error("second return cycle not idle");
	chk_call_push: assert property (
		stack_push_o |-> pc_load_o &&
		stack_push_value_o == $past(pc_i) + CALL_RET_STEP &&
		pc_value_o[7:0] == $past(working_register_i))
		else $error("call push or target wrong");
	chk_push_decrement: assert property (
		mem_we_o && r.op == OP_PUSH |->
		third_pointer_register_o == mem_waddr_o - 12'h001)
		else $error("push did not decrement pointer");
	chk_ptr_write_phase: assert property (
		$changed(r.ptr) |-> phase_o == PH_DECODE)
		else $error("pointer written outside write phase");
	chk_move_addr: assert property (
		move_read_s |-> mem_raddr_o ==
		third_pointer_register_o + {5'h00, r.ir[6:0]})
		else $error("indexed source address wrong");
	chk_move_write: assert property (
		move_read_s |-> ##6 move_write_s)
		else $error("move did not write in second cycle");
endmodule // isd_decode

// [test/isd_decode_bench.sv]
module isd_decode_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import isd_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	logic clk_sys_i;
	logic rstn_i;
	logic [15:0] instr_word_i;
	logic ext_enable_i;
	logic [7:0] working_register_i;
	logic [7:0] counter_high_latch_i;
	logic [4:0] counter_upper_latch_i;
	logic [PC_W-1:0] pc_i;
	logic [PC_W-1:0] return_stack_top_i;
	logic [7:0] mem_rdata_i;
	logic [1:0] phase_o;
	logic claim_o;
	logic pc_load_o;
	logic [PC_W-1:0] pc_value_o;
	logic stack_pop_o;
	logic stack_push_o;
	logic [PC_W-1:0] stack_push_value_o;
	logic mem_re_o;
	logic [PTR_W-1:0] mem_raddr_o;
	logic mem_we_o;
	logic [PTR_W-1:0] mem_waddr_o;
	logic [7:0] mem_wdata_o;
	logic [PTR_W-1:0] pv [3];
	logic [PTR_W-1:0] e [3];
	int failures;
	int checks_done;
	int cycles;
	isd_decode i_dut
	(
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.instr_word_i(instr_word_i),
		.ext_enable_i(ext_enable_i),
		.working_register_i(working_register_i),
		.counter_high_latch_i(counter_high_latch_i),
		.counter_upper_latch_i(counter_upper_latch_i),
		.pc_i(pc_i),
		.return_stack_top_i(return_stack_top_i),
		.mem_rdata_i(mem_rdata_i),
		.phase_o(phase_o),
		.claim_o(claim_o),
		.pc_load_o(pc_load_o),
		.pc_value_o(pc_value_o),
		.stack_pop_o(stack_pop_o),
		.stack_push_o(stack_push_o),
		.stack_push_value_o(stack_push_value_o),
		.mem_re_o(mem_re_o),
		.mem_raddr_o(mem_raddr_o),
		.mem_we_o(mem_we_o),
		.mem_waddr_o(mem_waddr_o),
		.mem_wdata_o(mem_wdata_o),
		.pointer_register0_o(pv[0]),
		.pointer_register1_o(pv[1]),
		.third_pointer_register_o(pv[2])
	);
	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
			failures++;
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	// A word is offered in a phase 0 cycle and withdrawn one cycle later.
	task automatic issue(input logic [15:0] w);
		for (int i = 0; i < 8 && phase_o !== PH_DECODE; i++)
			step(1);
		instr_word_i = w;
		step(1);
		instr_word_i = 16'h0000;
	endtask
	task tally_and_finish;
		if (failures == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task t_disabled;
		ext_enable_i = 1'b0;
		issue({OPC_PTR_ADD, 2'h0, 6'h05});
		check(claim_o, 0);
		check(phase_o, PH_READ);
		step(3);
		check(pv[0], e[0]);
		ext_enable_i = 1'b1;
	endtask
	task t_adjust;
		for (int s = 0; s < 2; s++)
			for (int f = 0; f < 3; f++)
			begin
				issue({s ? OPC_PTR_ADD : OPC_PTR_SUB, 2'(f), 6'h3F});
				check(claim_o, 1);
				step(3);
				e[f] = s ? e[f] + 12'h03F : e[f] - 12'h03F;
				check(pv[f], e[f]);
				check(pc_load_o, 0);
			end
	endtask
	task automatic t_ret(input logic sub);
		return_stack_top_i = sub ? 21'h0_6789 : 21'h1_2345;
		issue({sub ? OPC_PTR_SUB : OPC_PTR_ADD, SEL_THIRD, 6'h23});
		step(3);
		e[2] = sub ? e[2] - 12'h023 : e[2] + 12'h023;
		check(pv[2], e[2]);
		check(pv[0], e[0]);
		check({pc_load_o, stack_pop_o}, 3);
		check(pc_value_o, sub ? 21'h0_6789 : 21'h1_2345);
		issue({OPC_PUSH, 8'h77});
		step(3);
		check({mem_we_o, pc_load_o}, 0);
		check(pv[2], e[2]);
	endtask
	task t_push;
		issue({OPC_PUSH, 8'hA5});
		step(3);
		check({mem_we_o, mem_waddr_o, mem_wdata_o}, {1'b1, e[2], 8'hA5});
		e[2] = e[2] - 12'h001;
		check(pv[2], e[2]);
	endtask
	task t_call;
		working_register_i = 8'h5A;
		counter_high_latch_i = 8'hC3;
		counter_upper_latch_i = 5'h1B;
		pc_i = 21'h0_1FFF;
		issue(OPC_WORKING_REGISTER_CALL);
		check(claim_o, 1);
		step(3);
		check({pc_load_o, stack_push_o}, 3);
		check(pc_value_o, {5'h1B, 8'hC3, 8'h5A});
		check(stack_push_value_o, 21'h0_2001);
		check(claim_o, 1);
		step(4);
		check(pv[2], e[2]);
	endtask
	task automatic t_move(input logic idx);
		mem_rdata_i = idx ? 8'h3C : 8'hC9;
		issue({OPC_MOVE, idx, 7'h05});
		step(1);
		check({mem_re_o, mem_raddr_o}, {1'b1, e[2] + 12'h005});
		step(2);
		issue(idx ? 16'hFF8A : 16'hF123);
		step(3);
		check(mem_we_o, 1);
		check(mem_waddr_o, idx ? 12'(e[2] + 12'h00A) : 12'h123);
		check(mem_wdata_o, mem_rdata_i);
	endtask
	// Reset in mid-run clears all state; the first edge after release
	// already takes a word.
	task t_reset;
		rstn_i = 1'b0;
		step(2);
		check({phase_o, claim_o, mem_we_o, pv[2]}, 0);
		e = '{default: PTR_RESET};
		rstn_i = 1'b1;
		issue({OPC_PTR_ADD, 2'h1, 6'h11});
		check(claim_o, 1);
		step(3);
		check(pv[1], 12'h011);
		check(pv[2], e[2]);
	endtask
	// ****************************************
	// Clock, timeout and main sequence
	// ****************************************
	initial
	begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (cycles == 1000)
		begin
			failures++;
			tally_and_finish;
		end
	end
	initial
	begin
		{instr_word_i, working_register_i, counter_high_latch_i} = '0;
		{counter_upper_latch_i, pc_i, return_stack_top_i, mem_rdata_i} = '0;
		ext_enable_i = 1'b1;
		rstn_i = 1'b0;
		e = '{default: PTR_RESET};
		repeat (5) @(posedge clk_sys_i);
		#1;
		rstn_i = 1'b1;
		t_disabled;
		t_adjust;
		t_ret(1'b0);
		t_ret(1'b1);
		t_push;
		t_call;
		t_move(1'b0);
		t_move(1'b1);
		t_reset;
		tally_and_finish;
	end
endmodule // isd_decode_bench
